//--- verilog/acf_pkg.sv
package acf_pkg;
    localparam int ACF_ADDR_W = 6;
    localparam int ACF_SAMPLE_W = 16;
    localparam int ACF_DEPTH = 32;
    localparam int ACF_CNT_W = 6;
    localparam logic [5:0] ACF_X_LO_OFS = 6'h32;
    localparam logic [5:0] ACF_X_HI_OFS = 6'h33;
    localparam logic [5:0] ACF_Y_LO_OFS = 6'h34;
    localparam logic [5:0] ACF_Y_HI_OFS = 6'h35;
    localparam logic [5:0] ACF_Z_LO_OFS = 6'h36;
    localparam logic [5:0] ACF_Z_HI_OFS = 6'h37;
    localparam logic [5:0] ACF_CTL_OFS = 6'h38;
    localparam logic [5:0] ACF_STATUS_OFS = 6'h39;
    localparam int ACF_MODE_MSB = 7;
    localparam int ACF_MODE_LSB = 6;
    localparam int ACF_TRIG_SRC_BIT = 5;
    localparam int ACF_SAMPLES_MSB = 4;
    localparam int ACF_STATUS_TRIG_BIT = 7;
    localparam int ACF_MAP_DRDY_BIT = 2;
    localparam int ACF_MAP_WM_BIT = 1;
    localparam int ACF_MAP_OVR_BIT = 0;
    localparam logic [7:0] ACF_CTL_RST = 8'h00;
    typedef enum logic [1:0]
    {
        ACF_MODE_BYPASS = 2'b00,
        ACF_MODE_FILL = 2'b01,
        ACF_MODE_STREAM = 2'b10,
        ACF_MODE_TRIGGER = 2'b11
    } acf_mode_t;
endpackage

//--- verilog/acf_sticky_flag.sv
`timescale 1ns/1ps
module acf_sticky_flag
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic flag_out
);
    // Set wins so an event landing on a clearing read is kept
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            flag_out <= 1'b0;
        else if (set_in)
            flag_out <= 1'b1;
        else if (clr_in)
            flag_out <= 1'b0;
    end
endmodule

//--- verilog/acf_sample_fifo.sv
`timescale 1ns/1ps
module acf_sample_fifo
#(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32,
    parameter int CNT_W = 6
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic flush_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out,
    output logic [CNT_W-1:0] count_out
);
    localparam int PTR_W = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || CNT_W < PTR_W + 1
        || WIDTH < 1)
    begin
        $error("fifo depth must be a power of two and fit the count");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    wire full = count_out == CNT_W'(DEPTH);
    wire do_pop = rd_valid_out & rd_ready_in;
    // A full buffer still takes a word when the head leaves this cycle
    wire do_push = wr_valid_in & wr_ready_out;

    assign rd_valid_out = count_out != '0;
    assign wr_ready_out = ~full | rd_ready_in;
    assign rd_data_out = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_in)
    begin
        if (do_push)
            mem_reg[wr_ptr_reg] <= wr_data_in;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_out <= '0;
        end
        else if (flush_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_out <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (do_pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (do_push & ~do_pop)
                count_out <= count_out + 1'b1;
            else if (do_pop & ~do_push)
                count_out <= count_out - 1'b1;
        end
    end
endmodule

//--- verilog/acf_output_buffer.sv
`timescale 1ns/1ps
module acf_output_buffer
    import acf_pkg::*;
#(
    parameter int SAMPLE_W = acf_pkg::ACF_SAMPLE_W,
    parameter int DEPTH = acf_pkg::ACF_DEPTH
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [acf_pkg::ACF_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic reg_txn_in,
    output logic [7:0] reg_rdata_out,
    // Sample source
    input wire logic sample_valid_in,
    output logic sample_ready_out,
    input wire logic [SAMPLE_W-1:0] sample_x_in,
    input wire logic [SAMPLE_W-1:0] sample_y_in,
    input wire logic [SAMPLE_W-1:0] sample_z_in,
    // Device context
    input wire logic sleep_in,
    input wire logic [2:0] int_map_in,
    input wire logic first_interrupt_line_in,
    input wire logic second_interrupt_line_in,
    output logic data_ready_flag_out,
    output logic watermark_flag_out,
    output logic overrun_flag_out,
    output logic first_line_req_out,
    output logic second_line_req_out
);
    import acf_pkg::*;

    localparam int WORD_W = 3 * SAMPLE_W;

    // Byte map fixes the sample width; status count limits the depth
    if (SAMPLE_W != 16 || DEPTH < 2 || DEPTH > 32
        || (1 << $clog2(DEPTH)) != DEPTH
        || ACF_CNT_W < $clog2(DEPTH) + 1)
    begin
        $error("sample width must be 16, depth a power of two to 32");
    end

    logic [7:0] ctl_reg;
    logic trig_seen_reg;
    logic first_dly_reg;
    logic second_dly_reg;
    logic txn_dly_reg;
    logic pop_pend_reg;
    logic out_valid_reg;
    logic [WORD_W-1:0] out_data_reg;
    logic [7:0] rdata_reg;
    logic ready_reg;
    logic first_req_reg;
    logic second_req_reg;

    wire [ACF_CNT_W-1:0] fifo_count;
    wire fifo_wr_ready;
    wire fifo_rd_valid;
    wire [WORD_W-1:0] fifo_rd_data;
    wire flag_drdy;
    wire flag_wm;
    wire flag_ovr;

    // Control field decode
    wire [1:0] mode = ctl_reg[ACF_MODE_MSB:ACF_MODE_LSB];
    wire trig_src = ctl_reg[ACF_TRIG_SRC_BIT];
    wire [4:0] samples = ctl_reg[ACF_SAMPLES_MSB:0];
    wire [ACF_CNT_W-1:0] samples_ext = {1'b0, samples};
    wire is_bypass = mode == ACF_MODE_BYPASS;
    wire is_fill = mode == ACF_MODE_FILL;
    wire is_stream = mode == ACF_MODE_STREAM;
    wire is_trig = mode == ACF_MODE_TRIGGER;

    // Register access decode
    wire ctl_wr = reg_wr_in & (reg_addr_in == ACF_CTL_OFS);
    wire [1:0] wr_mode = reg_wdata_in[ACF_MODE_MSB:ACF_MODE_LSB];
    wire mode_change = ctl_wr & (wr_mode != mode);
    wire zero_wr = ctl_wr & (reg_wdata_in[ACF_SAMPLES_MSB:0] == 5'h00);
    wire data_addr = (reg_addr_in >= ACF_X_LO_OFS)
        & (reg_addr_in <= ACF_Z_HI_OFS);
    wire data_rd = reg_rd_in & data_addr;
    // Pop only at the end of the transaction, so a burst sees one sample
    wire txn_end = txn_dly_reg & ~reg_txn_in;
    wire host_pop = txn_end & (pop_pend_reg | (data_rd & txn_dly_reg));

    // Trigger capture from the selected line; each line keeps its own
    // history so flipping the source bit cannot fake an edge
    wire first_rise = first_interrupt_line_in & ~first_dly_reg;
    wire second_rise = second_interrupt_line_in & ~second_dly_reg;
    wire line_rise = trig_src ? second_rise : first_rise;
    wire trig_event = is_trig & ~trig_seen_reg & line_rise;

    // Sample routing
    wire [WORD_W-1:0] sample_word = {sample_z_in, sample_y_in, sample_x_in};
    wire sample_take = sample_valid_in & ~sleep_in & ~is_bypass;
    wire fifo_full = fifo_count == ACF_CNT_W'(DEPTH);
    wire pre_limit = is_trig & ~trig_seen_reg
        & (fifo_count >= samples_ext) & (samples != 5'h00);
    // Output stage is the extra readable entry beyond the buffer
    wire out_free = ~out_valid_reg | host_pop;
    wire load_out = ~is_bypass & fifo_rd_valid & out_free & ~reg_txn_in;
    wire bypass_load = is_bypass & sample_valid_in & ~reg_txn_in;
    // A head that moves into the output stage is kept, not dropped
    wire discard = sample_take & fifo_rd_valid & ~load_out
        & ((is_stream & fifo_full) | pre_limit);
    wire fifo_rd_ready = load_out | discard;
    // Fill-once and post-trigger storage drop the sample when full
    wire sample_lost = sample_take & ~fifo_wr_ready;
    // Bypass cannot refresh the output mid-burst, so that sample is lost
    wire bypass_lost = is_bypass & sample_valid_in & reg_txn_in;
    wire overrun_evt = sample_lost | discard | bypass_lost
        | (bypass_load & out_valid_reg & ~host_pop);
    wire drdy_evt = (load_out | bypass_load) & ~sleep_in;
    wire wm_cond = (is_fill | is_stream) & fifo_count != '0
        & (fifo_count >= samples_ext);
    wire wm_set = wm_cond | zero_wr;

    // Read data selection
    wire [15:0] x_word = out_data_reg[SAMPLE_W-1:0];
    wire [15:0] y_word = out_data_reg[2*SAMPLE_W-1:SAMPLE_W];
    wire [15:0] z_word = out_data_reg[3*SAMPLE_W-1:2*SAMPLE_W];
    wire [7:0] status_byte = {trig_seen_reg, 1'b0, fifo_count};
    logic [7:0] rd_mux;

    always_comb
    begin
        case (reg_addr_in)
            ACF_X_LO_OFS: rd_mux = x_word[7:0];
            ACF_X_HI_OFS: rd_mux = x_word[15:8];
            ACF_Y_LO_OFS: rd_mux = y_word[7:0];
            ACF_Y_HI_OFS: rd_mux = y_word[15:8];
            ACF_Z_LO_OFS: rd_mux = z_word[7:0];
            ACF_Z_HI_OFS: rd_mux = z_word[15:8];
            ACF_CTL_OFS: rd_mux = ctl_reg;
            ACF_STATUS_OFS: rd_mux = status_byte;
            default: rd_mux = 8'h00;
        endcase
    end

    // Route flags to the two interrupt lines
    wire [2:0] flags_vec = {flag_drdy, flag_wm, flag_ovr};
    wire first_req_next = |(flags_vec & ~int_map_in);
    wire second_req_next = |(flags_vec & int_map_in);

    acf_sample_fifo
    #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH),
        .CNT_W(ACF_CNT_W)
    )
    u_fifo
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .flush_in(mode_change),
        .wr_valid_in(sample_take),
        .wr_ready_out(fifo_wr_ready),
        .wr_data_in(sample_word),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in(fifo_rd_ready),
        .rd_data_out(fifo_rd_data),
        .count_out(fifo_count)
    );

    acf_sticky_flag u_drdy
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(drdy_evt),
        .clr_in(host_pop & ~fifo_rd_valid),
        .flag_out(flag_drdy)
    );

    acf_sticky_flag u_wm
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(wm_set),
        .clr_in(host_pop),
        .flag_out(flag_wm)
    );

    acf_sticky_flag u_ovr
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(overrun_evt),
        .clr_in(host_pop),
        .flag_out(flag_ovr)
    );

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ctl_reg <= ACF_CTL_RST;
        else if (ctl_wr)
            ctl_reg <= reg_wdata_in;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            trig_seen_reg <= 1'b0;
        else if (trig_event)
            trig_seen_reg <= 1'b1;
        else if (mode_change)
            trig_seen_reg <= 1'b0;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            txn_dly_reg <= 1'b0;
        else
            txn_dly_reg <= reg_txn_in;
    end

    // Lines idle low, so a zero history gives no edge after reset
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            first_dly_reg <= 1'b0;
            second_dly_reg <= 1'b0;
        end
        else
        begin
            first_dly_reg <= first_interrupt_line_in;
            second_dly_reg <= second_interrupt_line_in;
        end
    end

    // Any data byte read in the transaction arms one pop
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pop_pend_reg <= 1'b0;
        else if (txn_end)
            pop_pend_reg <= 1'b0;
        else if (data_rd)
            pop_pend_reg <= 1'b1;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end
        else if (load_out)
        begin
            out_valid_reg <= 1'b1;
            out_data_reg <= fifo_rd_data;
        end
        else if (bypass_load)
        begin
            // Bypass still refreshes output while asleep
            out_valid_reg <= 1'b1;
            out_data_reg <= sample_word;
        end
        else if (host_pop)
            out_valid_reg <= 1'b0;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rdata_reg <= 8'h00;
        else if (reg_rd_in)
            rdata_reg <= rd_mux;
    end

    // Advisory: the sensor never waits, refused samples count as overrun except while asleep outside bypass, when they are ignored
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ready_reg <= 1'b0;
            first_req_reg <= 1'b0;
            second_req_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= ~sleep_in & (is_bypass | is_stream | ~fifo_full);
            first_req_reg <= first_req_next;
            second_req_reg <= second_req_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign sample_ready_out = ready_reg;
    assign data_ready_flag_out = flag_drdy;
    assign watermark_flag_out = flag_wm;
    assign overrun_flag_out = flag_ovr;
    assign first_line_req_out = first_req_reg;
    assign second_line_req_out = second_req_reg;
endmodule

//--- verification/acf_buffer_monitor.sv
`timescale 1ns/1ps
module acf_buffer_monitor
    import acf_pkg::*;
#(
    parameter int DEPTH = 32
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic reg_txn_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic sample_valid_in,
    input wire logic sample_ready_out,
    input wire logic sleep_in,
    input wire logic [2:0] int_map_in,
    input wire logic data_ready_flag_out,
    input wire logic watermark_flag_out,
    input wire logic overrun_flag_out,
    input wire logic first_line_req_out,
    input wire logic second_line_req_out
);
    logic [7:0] ctl_shadow_reg;
    logic data_seen_reg;
    logic [2:0] flags;
    logic route1;
    logic route2;
    logic data_rd;
    logic stat_rd;
    assign flags = {data_ready_flag_out, watermark_flag_out, overrun_flag_out};
    assign route1 = |(flags & ~int_map_in);
    assign route2 = |(flags & int_map_in);
    assign data_rd = reg_rd_in && reg_addr_in >= ACF_X_LO_OFS
        && reg_addr_in <= ACF_Z_HI_OFS;
    assign stat_rd = reg_rd_in && reg_addr_in == ACF_STATUS_OFS;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ctl_shadow_reg <= ACF_CTL_RST;
        else if (reg_wr_in && reg_addr_in == ACF_CTL_OFS)
            ctl_shadow_reg <= reg_wdata_in;
    end
    // Remembers a data read until the burst closes
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            data_seen_reg <= 1'b0;
        else
            data_seen_reg <= reg_txn_in && (data_seen_reg || data_rd);
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_burst_end;
        data_seen_reg && reg_txn_in ##1 !reg_txn_in;
    endsequence
    sequence s_quiet;
        !sample_valid_in [*4];
    endsequence
    AST_UNMAPPED: assert property (reg_rd_in && (reg_addr_in < ACF_X_LO_OFS
        || reg_addr_in > ACF_STATUS_OFS) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_STAT_GAP: assert property (stat_rd |=> !reg_rdata_out[6])
        else $error("status bit 6 set");
    AST_STAT_COUNT: assert property (stat_rd |=> reg_rdata_out[5:0] <= DEPTH)
        else $error("entry count above depth");
    AST_CTL_BACK: assert property (reg_rd_in && reg_addr_in == ACF_CTL_OFS
        |=> reg_rdata_out == ctl_shadow_reg)
        else $error("control readback wrong");
    AST_WM_ZERO: assert property (reg_wr_in && reg_addr_in == ACF_CTL_OFS
        && reg_wdata_in[4:0] == 5'h00 |-> ##[1:2] watermark_flag_out)
        else $error("zero samples did not set watermark");
    AST_LINE_ONE: assert property (first_line_req_out == $past(route1))
        else $error("first line request wrong");
    AST_LINE_TWO: assert property (second_line_req_out == $past(route2))
        else $error("second line request wrong");
    AST_SLEEP_READY: assert property ($past(sleep_in) && sleep_in
        |-> !sample_ready_out)
        else $error("ready while asleep");
    AST_POP_OVR: assert property (s_burst_end ##0 s_quiet
        |-> !overrun_flag_out)
        else $error("overrun not cleared by data read");
endmodule

//--- verification/acf_host_model.sv
`timescale 1ns/1ps
module acf_host_model
(
    input wire logic clk_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [5:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out,
    output logic reg_txn_out
);
    initial
    begin
        reg_addr_out = 6'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
        reg_txn_out = 1'b0;
    end
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_txn_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge clk_in);
        reg_wr_out = 1'b0;
        reg_txn_out = 1'b0;
        // Released lines do not keep the last value
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
        @(negedge clk_in);
    endtask
    // One burst per sample, so the output stage cannot move mid-read
    task automatic read_regs(input logic [5:0] a, input int n,
        output logic [7:0] q [0:5]);
        @(negedge clk_in);
        reg_txn_out = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_in);
            if (i > 0)
                q[i-1] = reg_rdata_in;
            reg_addr_out = a + 6'(i);
            reg_rd_out = 1'b1;
        end
        @(negedge clk_in);
        q[n-1] = reg_rdata_in;
        reg_rd_out = 1'b0;
        reg_txn_out = 1'b0;
        reg_addr_out = ~reg_addr_out;
        repeat (3) @(negedge clk_in);
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    import acf_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [5:0] reg_addr_in;
    logic reg_wr_in;
    logic [7:0] reg_wdata_in;
    logic reg_rd_in;
    logic reg_txn_in;
    logic [7:0] reg_rdata_out;
    logic sample_valid_in = 1'b0;
    logic [15:0] sx = 16'h0000;
    logic [15:0] sy = 16'h0000;
    logic [15:0] sz = 16'h0000;
    logic sleep_in = 1'b0;
    logic [2:0] int_map_in = 3'b010;
    logic line1 = 1'b0;
    logic line2 = 1'b0;
    logic ready, drdy, wm, ovr, req1, req2;
    logic [7:0] q [0:5];
    int mismatches = 0;
    int samples_checked = 0;
    always #2.5 clk_in = ~clk_in;
    acf_output_buffer acf_output_buffer_inst (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rd_in(reg_rd_in), .reg_txn_in(reg_txn_in),
        .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
        .sample_ready_out(ready), .sample_x_in(sx), .sample_y_in(sy),
        .sample_z_in(sz), .sleep_in(sleep_in), .int_map_in(int_map_in),
        .first_interrupt_line_in(line1), .second_interrupt_line_in(line2),
        .data_ready_flag_out(drdy), .watermark_flag_out(wm),
        .overrun_flag_out(ovr), .first_line_req_out(req1),
        .second_line_req_out(req2));
    acf_host_model acf_host_model_inst (.clk_in(clk_in),
        .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
        .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in),
        .reg_rd_out(reg_rd_in), .reg_txn_out(reg_txn_in));
    // Negative words for low indices exercise the sign byte
    function automatic logic [15:0] smp(input int k, input int a);
        return {8'(k) ^ 8'h80, 8'(a) ^ 8'h5a};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
        acf_host_model_inst.read_regs(a, 1, q);
        chk(q[0], exp);
    endtask
    task automatic chk_flags(input logic [2:0] f, input logic [1:0] l);
        chk({3'h0, drdy, wm, ovr, req1, req2}, {3'h0, f, l});
    endtask
    task automatic chk_sample(input int k);
        logic [15:0] w;
        acf_host_model_inst.read_regs(ACF_X_LO_OFS, 6, q);
        for (int a = 0; a < 3; a++)
        begin
            w = smp(k, a);
            chk(q[2*a], w[7:0]);
            chk(q[2*a+1], w[15:8]);
        end
    endtask
    task automatic push(input int k, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_in);
            sample_valid_in = 1'b1;
            sx = smp(k + i, 0);
            sy = smp(k + i, 1);
            sz = smp(k + i, 2);
        end
        @(negedge clk_in);
        sample_valid_in = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic reset();
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic wr(input logic [7:0] d);
        acf_host_model_inst.write_reg(ACF_CTL_OFS, d);
    endtask
    task automatic t_reset();
        chk_reg(ACF_CTL_OFS, 8'h00);
        chk_reg(ACF_STATUS_OFS, 8'h00);
        chk_reg(6'h20, 8'h00);
        chk_flags(3'b000, 2'b00);
    endtask
    task automatic t_wm_zero();
        wr(8'h00);
        repeat (2) @(negedge clk_in);
        chk_flags(3'b010, 2'b01);
    endtask
    task automatic t_bypass();
        reset();
        chk({7'h00, ready}, 8'h01);
        push(5, 1);
        chk_flags(3'b100, 2'b10);
        chk_sample(5);
        chk_flags(3'b000, 2'b00);
    endtask
    task automatic t_fill();
        reset();
        wr(8'h50);
        push(0, 1);
        push(1, 33);
        chk_reg(ACF_STATUS_OFS, 8'h20);
        chk_flags(3'b111, 2'b11);
        chk({7'h00, ready}, 8'h00);
        chk_sample(0);
        chk_flags(3'b110, 2'b11);
        chk_sample(1);
        chk_reg(ACF_STATUS_OFS, 8'h1e);
    endtask
    task automatic t_stream();
        reset();
        wr(8'h88);
        push(0, 1);
        push(1, 40);
        chk_reg(ACF_STATUS_OFS, 8'h20);
        chk_sample(0);
        chk_sample(9);
    endtask
    task automatic t_trig();
        reset();
        wr(8'he4);
        push(0, 1);
        push(1, 10);
        chk_reg(ACF_STATUS_OFS, 8'h04);
        line1 = 1'b1;
        @(negedge clk_in);
        line1 = 1'b0;
        chk_reg(ACF_STATUS_OFS, 8'h04);
        line2 = 1'b1;
        @(negedge clk_in);
        line2 = 1'b0;
        chk_reg(ACF_STATUS_OFS, 8'h84);
        push(11, 40);
        chk_reg(ACF_STATUS_OFS, 8'ha0);
        chk_sample(0);
        chk_sample(7);
    endtask
    task automatic t_trig_first();
        reset();
        wr(8'hc2);
        line2 = 1'b1;
        @(negedge clk_in);
        line2 = 1'b0;
        chk_reg(ACF_STATUS_OFS, 8'h00);
        line1 = 1'b1;
        @(negedge clk_in);
        line1 = 1'b0;
        chk_reg(ACF_STATUS_OFS, 8'h80);
    endtask
    task automatic t_sleep();
        reset();
        wr(8'h81);
        sleep_in = 1'b1;
        push(0, 3);
        chk_reg(ACF_STATUS_OFS, 8'h00);
        chk_flags(3'b000, 2'b00);
        chk({7'h00, ready}, 8'h00);
        sleep_in = 1'b0;
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        reset();
        t_reset();
        t_wm_zero();
        t_bypass();
        t_fill();
        t_stream();
        t_trig();
        t_trig_first();
        t_sleep();
        results();
    end
    // Whole run takes about 1.8 us
    initial
    begin
        #20000;
        mismatches++;
        results();
    end
endmodule
bind acf_output_buffer acf_buffer_monitor #(.DEPTH(DEPTH))
    acf_buffer_monitor_inst (.*);
